//--- encpd_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "encpd_params.svh"
// Overview of operation
// - Byte 39 bit 1 selects single or multi-turn.
// - Byte 39 bits 4,5 select speed time base.
// - Input word: 25 position bits, 7 status.
// - Status bits overwrite position bits above 25.
// - Device answers only when master reads.
// - Speed travels in a separate input word.
// - Master output word: commands high, value low.
// - Bit 25 shows ready to operate.
// - Bit 26 clear and LED flashes in commissioning.
// - Bit 27 set outside software limit window.
// - Bit 28 reports active counting direction.
// - Commissioning takes the counting direction from the nonvolatile store, not configuration.
// - Commissioning changes are stored nonvolatile.
// - Online direction change only in commissioning.
// - Falling output bit 28 flips direction.
// - Direction handshake echoes bits 28, 0, 25.
// - Byte 26 bit 2 enables commissioning mode.
// - Output bit 30 starts teach, raw position.
// - Output bit 29 stops teach, reports resolution.
// - Rising output bit 31 loads preset, acknowledged.
module encpd_core
  import encpd_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Raw position from the sensing disk, asynchronous to clk.
  input wire logic [24:0] raw_pos,
  // Device is ready to operate (pin).
  input wire logic ready_in,
  // AXI4-Lite write channels.
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read channels.
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Indicators and nonvolatile store strobe.
  output logic led_green,
  output logic nv_write
);
  // Pin synchronisers.
  logic [24:0] pos_s1_r, pos_s2_r;
  logic rdy_s1_r, rdy_s2_r;
  // Registers.
  logic [31:0] cfg_r, cfg_nxt; // Byte 39 in 7:0, byte 26 in 15:8, dir 16.
  logic [31:0] outw_r, outw_nxt; // Master output double word.
  logic [31:0] prev_r, prev_nxt; // Previous output word for edges.
  logic [31:0] lolim_r, lolim_nxt, hilim_r, hilim_nxt;
  logic nvdir_r, nvdir_nxt; // Direction held in nonvolatile store.
  logic [24:0] offs_r, offs_nxt; // Preset zero offset.
  logic [24:0] tstart_r, tstart_nxt; // Teach start raw position.
  logic [24:0] tres_r, tres_nxt; // Teach resolution taken from the master's output word.
  encpd_teach_t tst_r, tst_nxt;
  logic ack28_r, ack28_nxt; // Direction handshake in progress.
  logic nvw_r, nvw_nxt;
  logic [25:0] led_cnt_r, led_cnt_nxt;
  logic led_r, led_nxt;
  // Bus.
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [11:0] aw_r, aw_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  // Derived.
  logic comm, dir, lim, multi;
  logic [24:0] pos_dir, pos_out;
  logic [31:0] inw;
  logic [15:0] speed;
  encpd_tb_t tb;

  // Combinational check of a mapped offset.
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a <= `ENCPD_OFF_NVDIR) && (a[1:0] == 2'b00);
  endfunction

  // Byte-lane merge for writes.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
      input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  // Position datapath: direction, teach raw output, offset, field clipping.
  always_comb begin
    comm = cfg_r[`ENCPD_P26_COMM];
    multi = cfg_r[`ENCPD_P39_TYPE];
    tb = encpd_tb_t'({cfg_r[`ENCPD_P39_TB1], cfg_r[`ENCPD_P39_TB0]});
    // In commissioning the stored direction wins over configuration.
    dir = comm ? nvdir_r : cfg_r[`ENCPD_CFG_DIR];
    pos_dir = dir ? 25'(~pos_s2_r) : pos_s2_r;
    // Single-turn keeps only the low 13 bits of a revolution.
    if (!multi) begin
      pos_dir = {12'h0, pos_dir[12:0]};
    end
    // Teach running: factor one and no offset.
    pos_out = (tst_r == ENCPD_T_RUN) ? pos_dir : 25'(pos_dir - offs_r);
    lim = (cfg_r[`ENCPD_P26_LOEN] && ({7'h0, pos_out} < lolim_r)) ||
          (cfg_r[`ENCPD_P26_HIEN] && ({7'h0, pos_out} > hilim_r));
    // Status flags sit above the 25-bit field, so larger positions cannot pass.
    inw = {prev_r[31], 1'b0, 1'b0, dir, lim, ~comm, rdy_s2_r, pos_out};
    inw[`ENCPD_BIT_TSTART] = (tst_r != ENCPD_T_IDLE);
    inw[`ENCPD_BIT_TSTOP] = (tst_r == ENCPD_T_STOP);
    if (tst_r == ENCPD_T_STOP) begin
      inw[24:0] = tres_r;
    end
    if (ack28_r) begin
      // The acknowledge already shows the direction that the falling bit will select.
      inw[28:0] = {~dir, inw[27:25], 24'h0, ~dir};
    end
  end

  // Command decode of the master's output double word.
  always_comb begin
    prev_nxt = outw_r;
    nvdir_nxt = nvdir_r;
    offs_nxt = offs_r;
    tst_nxt = tst_r;
    tstart_nxt = tstart_r;
    tres_nxt = tres_r;
    ack28_nxt = ack28_r;
    nvw_nxt = 1'b0;
    // Direction handshake, only in commissioning.
    if (comm && outw_r[`ENCPD_BIT_DIR] && outw_r[31:29] == 3'h0) begin
      ack28_nxt = 1'b1;
    end
    if (comm && prev_r[`ENCPD_BIT_DIR] && !outw_r[`ENCPD_BIT_DIR]) begin
      nvdir_nxt = ~nvdir_r;
      ack28_nxt = 1'b0;
      nvw_nxt = 1'b1;
    end
    // Teach-in sequence.
    if (comm && outw_r[`ENCPD_BIT_TSTART] && tst_r == ENCPD_T_IDLE) begin
      tst_nxt = ENCPD_T_RUN;
      tstart_nxt = pos_dir;
    end
    if (comm && outw_r[`ENCPD_BIT_TSTOP] && tst_r == ENCPD_T_RUN) begin
      tst_nxt = ENCPD_T_STOP;
      tres_nxt = outw_r[24:0];
      offs_nxt = tstart_r;
      nvw_nxt = 1'b1;
    end
    if (tst_r == ENCPD_T_STOP && !outw_r[`ENCPD_BIT_TSTOP]) begin
      tst_nxt = ENCPD_T_IDLE;
    end
    // Preset on rising bit 31.
    if (outw_r[`ENCPD_BIT_PRESET] && !prev_r[`ENCPD_BIT_PRESET]) begin
      offs_nxt = 25'(pos_dir - outw_r[24:0]);
      nvw_nxt = 1'b1;
    end
    // LED flashes in commissioning, solid otherwise.
    led_cnt_nxt = (led_cnt_r >= 26'(`ENCPD_LED_HALF - 1)) ? 26'h0 : led_cnt_r + 26'h1;
    led_nxt = comm ? (led_cnt_r == 26'h0 ? ~led_r : led_r) : 1'b1;
  end

  // AXI4-Lite slave; the master initiates every exchange.
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    aw_nxt = aw_r;
    wd_nxt = wd_r;
    bv_nxt = bv_r;
    bresp_nxt = bresp_r;
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rresp_nxt = rresp_r;
    cfg_nxt = cfg_r;
    outw_nxt = outw_r;
    lolim_nxt = lolim_r;
    hilim_nxt = hilim_r;
    if (s_awvalid && !aw_got_r) begin
      aw_got_nxt = 1'b1;
      aw_nxt = s_awaddr;
    end
    if (s_wvalid && !w_got_r) begin
      w_got_nxt = 1'b1;
      wd_nxt = s_wdata;
    end
    if (aw_got_r && w_got_r && !bv_r) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bv_nxt = 1'b1;
      bresp_nxt = mapped(aw_r) ? 2'b00 : 2'b10;
      case (aw_r)
        `ENCPD_OFF_CFG: cfg_nxt = merge(cfg_r, wd_r, s_wstrb);
        `ENCPD_OFF_OUTW: outw_nxt = merge(outw_r, wd_r, s_wstrb);
        `ENCPD_OFF_LOLIM: lolim_nxt = merge(lolim_r, wd_r, s_wstrb);
        `ENCPD_OFF_HILIM: hilim_nxt = merge(hilim_r, wd_r, s_wstrb);
        default: ;
      endcase
    end
    if (bv_r && s_bready) begin
      bv_nxt = 1'b0;
    end
    if (s_arvalid && !rv_r) begin
      rv_nxt = 1'b1;
      rresp_nxt = mapped(s_araddr) ? 2'b00 : 2'b10;
      case (s_araddr)
        `ENCPD_OFF_CFG: rd_nxt = cfg_r;
        `ENCPD_OFF_OUTW: rd_nxt = outw_r;
        `ENCPD_OFF_POS: rd_nxt = {7'h0, pos_out};
        `ENCPD_OFF_INW: rd_nxt = inw;
        `ENCPD_OFF_SPD: rd_nxt = {16'h0, speed};
        `ENCPD_OFF_LOLIM: rd_nxt = lolim_r;
        `ENCPD_OFF_HILIM: rd_nxt = hilim_r;
        `ENCPD_OFF_NVDIR: rd_nxt = {31'h0, nvdir_r};
        default: rd_nxt = 32'h0;
      endcase
    end else if (rv_r && s_rready) begin
      rv_nxt = 1'b0;
    end
  end

  // Registers; the synchronisers' first stage feeds only the second.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_s1_r <= 25'h0;
      pos_s2_r <= 25'h0;
      rdy_s1_r <= 1'b0;
      rdy_s2_r <= 1'b0;
      cfg_r <= `ENCPD_CFG_RST;
      outw_r <= 32'h0;
      prev_r <= 32'h0;
      lolim_r <= 32'h0;
      hilim_r <= 32'hffff_ffff;
      nvdir_r <= 1'b0;
      offs_r <= 25'h0;
      tstart_r <= 25'h0;
      tres_r <= 25'h0;
      tst_r <= ENCPD_T_IDLE;
      ack28_r <= 1'b0;
      nvw_r <= 1'b0;
      led_cnt_r <= 26'h0;
      led_r <= 1'b0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_r <= 12'h0;
      wd_r <= 32'h0;
      bv_r <= 1'b0;
      bresp_r <= 2'b00;
      rv_r <= 1'b0;
      rd_r <= 32'h0;
      rresp_r <= 2'b00;
    end else begin
      pos_s1_r <= raw_pos;
      pos_s2_r <= pos_s1_r;
      rdy_s1_r <= ready_in;
      rdy_s2_r <= rdy_s1_r;
      cfg_r <= cfg_nxt;
      outw_r <= outw_nxt;
      prev_r <= prev_nxt;
      lolim_r <= lolim_nxt;
      hilim_r <= hilim_nxt;
      nvdir_r <= nvdir_nxt;
      offs_r <= offs_nxt;
      tstart_r <= tstart_nxt;
      tres_r <= tres_nxt;
      tst_r <= tst_nxt;
      ack28_r <= ack28_nxt;
      nvw_r <= nvw_nxt;
      led_cnt_r <= led_cnt_nxt;
      led_r <= led_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      aw_r <= aw_nxt;
      wd_r <= wd_nxt;
      bv_r <= bv_nxt;
      bresp_r <= bresp_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // Speed word computed on its own.
  encpd_speed u_speed (
    .clk(clk),
    .rst_b(rst_b),
    .pos(pos_out),
    .tb(tb),
    .steps_rev(25'h2000),
    .speed(speed)
  );

  assign s_awready = !aw_got_r;
  assign s_wready = !w_got_r;
  assign s_bvalid = bv_r;
  assign s_bresp = bresp_r;
  assign s_arready = !rv_r;
  assign s_rvalid = rv_r;
  assign s_rdata = rd_r;
  assign s_rresp = rresp_r;
  assign led_green = led_r;
  assign nv_write = nvw_r;

  // Direction only flips on a falling command bit while commissioning.
  dir_flip_a: assert property (@(posedge clk) disable iff (!rst_b)
    (comm && $fell(outw_r[28]) && $past(outw_r[28])) |=> (nvdir_r != $past(nvdir_r)))
    else $error("direction did not flip on falling bit 28");
  dir_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !comm |=> $stable(nvdir_r))
    else $error("direction changed outside commissioning");
  mode_bit_a: assert property (@(posedge clk) disable iff (!rst_b)
    inw[26] == !cfg_r[`ENCPD_P26_COMM])
    else $error("mode bit wrong");
  preset_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(outw_r[31]) |=> inw[31])
    else $error("preset not acknowledged");
  teach_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    (comm && outw_r[30] && tst_r == ENCPD_T_IDLE) |=> inw[30])
    else $error("teach start not echoed");
  teach_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
    (comm && outw_r[29] && tst_r == ENCPD_T_RUN) |=> inw[24:0] == $past(outw_r[24:0]))
    else $error("teach stop result wrong");
  ack_echo_a: assert property (@(posedge clk) disable iff (!rst_b)
    ack28_r |-> ((inw[0] == !dir) && (inw[28] == !dir)))
    else $error("direction echo mismatch");
  nv_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    (nvdir_r != $past(nvdir_r)) |-> nv_write)
    else $error("direction change not stored");
endmodule
`default_nettype wire

//--- encpd_params.svh
`ifndef ENCPD_PARAMS_SVH
`define ENCPD_PARAMS_SVH
// Register byte offsets on the AXI4-Lite slave.
`define ENCPD_OFF_CFG 12'h000
`define ENCPD_OFF_OUTW 12'h004
`define ENCPD_OFF_POS 12'h008
`define ENCPD_OFF_INW 12'h00c
`define ENCPD_OFF_SPD 12'h010
`define ENCPD_OFF_LOLIM 12'h014
`define ENCPD_OFF_HILIM 12'h018
`define ENCPD_OFF_NVDIR 12'h01c
// Parameter byte 39 field positions.
`define ENCPD_P39_TYPE 1
`define ENCPD_P39_TB0 4
`define ENCPD_P39_TB1 5
// Parameter byte 26 field positions (held in cfg bits 15:8).
`define ENCPD_P26_COMM 10
`define ENCPD_P26_LOEN 13
`define ENCPD_P26_HIEN 14
// Config bit carrying the configured counting direction.
`define ENCPD_CFG_DIR 16
// Cyclic word layout.
`define ENCPD_POS_W 25
`define ENCPD_BIT_RDY 25
`define ENCPD_BIT_MODE 26
`define ENCPD_BIT_LIM 27
`define ENCPD_BIT_DIR 28
`define ENCPD_BIT_TSTOP 29
`define ENCPD_BIT_TSTART 30
`define ENCPD_BIT_PRESET 31
// Time bases.
`define ENCPD_CLK_HZ 100000000
`define ENCPD_MS_10 10
`define ENCPD_MS_100 100
`define ENCPD_TICK_10MS (`ENCPD_CLK_HZ / 1000 * `ENCPD_MS_10)
`define ENCPD_LED_HALF 50000000
`define ENCPD_CFG_RST 32'h0000_0000
`endif

//--- encpd_pkg.sv
package encpd_pkg;
  // Speed output time base selected by byte 39 bits 4 and 5.
  typedef enum logic [1:0] {
    ENCPD_TB_SEC = 2'b00,
    ENCPD_TB_100MS = 2'b01,
    ENCPD_TB_10MS = 2'b10,
    ENCPD_TB_RPM = 2'b11
  } encpd_tb_t;
  // Teach-in state.
  typedef enum logic [1:0] {
    ENCPD_T_IDLE = 2'b00,
    ENCPD_T_RUN = 2'b01,
    ENCPD_T_STOP = 2'b10
  } encpd_teach_t;
endpackage

//--- encpd_speed.sv
`timescale 1ns/1ps
`default_nettype none
`include "encpd_params.svh"
// Speed measurement: position difference over a 10 ms window, scaled to the base.
module encpd_speed
  import encpd_pkg::*;
#(
  parameter int unsigned TICK_10MS = `ENCPD_TICK_10MS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Position and selection.
  input wire logic [24:0] pos,
  input wire encpd_tb_t tb,
  input wire logic [24:0] steps_rev,
  // Speed result.
  output logic [15:0] speed
);
  logic [31:0] cnt_r, cnt_nxt; // Window counter.
  logic [24:0] last_r, last_nxt; // Position at previous window.
  logic [15:0] spd_r, spd_nxt; // Registered speed.
  logic [31:0] d; // Signed step delta over 10 ms.

  // Delta is taken modulo the 25-bit range so wrap past zero stays small.
  always_comb begin
    d = 32'(signed'({{7{pos[24] ^ last_r[24]}}, 25'(pos - last_r)}));
    d = {{7{d[24]}}, d[24:0]};
    cnt_nxt = cnt_r + 32'h1;
    last_nxt = last_r;
    spd_nxt = spd_r;
    if (cnt_r >= TICK_10MS - 1) begin
      cnt_nxt = 32'h0;
      last_nxt = pos;
      // Scale 10 ms delta to the chosen base; rpm uses 6000 windows per minute.
      case (tb)
        ENCPD_TB_SEC: spd_nxt = 16'(d * 32'd100);
        ENCPD_TB_100MS: spd_nxt = 16'(d * 32'd10);
        ENCPD_TB_10MS: spd_nxt = d[15:0];
        ENCPD_TB_RPM: spd_nxt = (steps_rev == 25'h0) ? 16'h0 :
          16'($signed(d) * 32'sd6000 / $signed({7'h0, steps_rev}));
        default: spd_nxt = 16'h0;
      endcase
    end
  end

  // Registers only.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 32'h0;
      last_r <= 25'h0;
      spd_r <= 16'h0;
    end else begin
      cnt_r <= cnt_nxt;
      last_r <= last_nxt;
      spd_r <= spd_nxt;
    end
  end

  assign speed = spd_r;
endmodule
`default_nettype wire

//--- encpd_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the bus master: it starts every exchange and holds each request until taken.
module encpd_master_model (
  // Clock.
  input wire logic clk,
  // Write channels.
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels.
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  // Wait bound in cycles; a stuck slave ends the wait with the timeout flag set.
  localparam int LIM = 200;
  // Idle levels at time zero; all valid and ready lines stay low until a request is made.
  initial begin
    awaddr = 12'h000;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 12'h000;
    arvalid = 1'b0;
    rready = 1'b0;
  end
  // One write: address and data go out together, each dropped once taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r,
                    output bit to);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      // A taken address no longer shows its old value.
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
    end while (!(bvalid && bready) && n < LIM);
    r = bresp;
    bready <= 1'b0;
    to = (n >= LIM);
  endtask
  // One read; the bench's monitor takes the data at the edge where rvalid is seen.
  task automatic rd(input logic [11:0] a, output bit to);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (!(rvalid && rready) && n < LIM);
    rready <= 1'b0;
    to = (n >= LIM);
  endtask
endmodule
`default_nettype wire

//--- tb_encoder_process_data_commissioning.sv
`timescale 1ns/1ps
`default_nettype none
`include "encpd_params.svh"
// Bench: the driver notes expected read data, the monitor compares each read answer.
module tb_encoder_process_data_commissioning;
  // Clock, reset and sensor side.
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [24:0] raw_pos = 25'h0000000;
  logic ready_in = 1'b1;
  // Bus wires between the master model and the block.
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic led_green, nv_write;
  // Expectation queues and counters.
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [1:0] rsp_q[$];
  logic [31:0] e, mk;
  logic [1:0] er;
  int fails = 0;
  int tests_run = 0;
  int nvw = 0;
  int n0, tnum = 0;
  int seed = 94;
  logic [24:0] v;
  logic [24:0] lv[5] = '{25'h63, 25'h64, 25'hc8, 25'hc9, 25'h96};
  logic lf[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  // Free-running 100 MHz clock.
  always #5 clk = ~clk;
  encpd_core uut (.clk(clk), .rst_b(rst_b), .raw_pos(raw_pos), .ready_in(ready_in),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
    .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
    .s_rready(rready), .led_green(led_green), .nv_write(nv_write));
  encpd_master_model m (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rready(rready));
  // Count store strobes, so each stored change can be seen as one more pulse.
  always @(posedge clk) begin
    if (nv_write === 1'b1) begin
      nvw++;
    end
  end
  // Every read answer is matched, under its mask, against the oldest note.
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      tests_run++;
      if (exp_q.size() == 0) begin
        fails++;
        $display("MISMATCH read answer expected none seen %h", rdata);
      end else begin
        e = exp_q.pop_front();
        mk = msk_q.pop_front();
        er = rsp_q.pop_front();
        if (((rdata ^ e) & mk) !== 32'h0 || rresp !== er) begin
          fails++;
          $display("MISMATCH rdata/rresp expected %h/%b seen %h/%b", e & mk, er, rdata & mk, rresp);
        end
      end
    end
  end
  // Verdict; also reached when any wait runs out.
  task automatic close_out();
    $display("Counts: %0d comparisons, %0d mismatches", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Write through the master model and check the response code.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] x = 2'b00);
    logic [1:0] r;
    bit to;
    m.wr(a, d, r, to);
    tests_run++;
    if (to || r !== x) begin
      fails++;
      $display("MISMATCH bresp at %h expected %b seen %b", a, x, r);
      if (to) close_out();
    end
    repeat (4) @(posedge clk);
  endtask
  // Note an expectation, then read; the monitor makes the comparison.
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] k,
                    input logic [1:0] xr = 2'b00);
    bit to;
    exp_q.push_back(x);
    msk_q.push_back(k);
    rsp_q.push_back(xr);
    m.rd(a, to);
    if (to) begin
      fails++;
      $display("MISMATCH read wait at %h expected answer seen none", a);
      close_out();
    end
  endtask
  // Move the sensor and let the two-flop synchroniser settle.
  task automatic pos(input logic [24:0] p);
    @(posedge clk);
    raw_pos <= p;
    repeat (6) @(posedge clk);
  endtask
  task automatic done();
    tnum++;
    $display("Test %0d finished, %0d mismatches so far", tnum, fails);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    // Multi-turn, full-width position: status bits sit above bit 24.
    wr(`ENCPD_OFF_CFG, 32'h2);
    pos(25'h1ffffff);
    rd(`ENCPD_OFF_INW, 32'h07ff_ffff, 32'hffff_ffff);
    rd(`ENCPD_OFF_POS, 32'h01ff_ffff, 32'h01ff_ffff);
    tests_run++;
    if (led_green !== 1'b1) begin
      fails++;
      $display("MISMATCH led_green expected 1 seen %b", led_green);
    end
    @(posedge clk);
    ready_in <= 1'b0;
    repeat (6) @(posedge clk);
    rd(`ENCPD_OFF_INW, 32'h0, 32'h0200_0000);
    @(posedge clk);
    ready_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      pos(v);
      rd(`ENCPD_OFF_INW, {7'h03, v}, 32'hffff_ffff);
    end
    wr(`ENCPD_OFF_CFG, 32'h0);
    rd(`ENCPD_OFF_INW, {7'h03, v & 25'h1fff}, 32'h01ff_ffff);
    done();
    // Every speed time base; a still shaft reads zero.
    for (int t = 0; t < 4; t++) begin
      wr(`ENCPD_OFF_CFG, 32'h2 | (t << 4));
      rd(`ENCPD_OFF_SPD, 32'h0, 32'h0000_ffff);
    end
    done();
    // Limit window edges: inclusive inside, one step out on either side.
    wr(`ENCPD_OFF_LOLIM, 32'd100);
    wr(`ENCPD_OFF_HILIM, 32'd200);
    wr(`ENCPD_OFF_CFG, 32'h6002);
    for (int i = 0; i < 5; i++) begin
      pos(lv[i]);
      rd(`ENCPD_OFF_INW, {4'h0, lf[i], 27'h0}, 32'h0800_0000);
    end
    wr(`ENCPD_OFF_CFG, 32'h2);
    done();
    // Unmapped place answers with a slave error and zero data.
    rd(12'h0f0, 32'h0, 32'hffff_ffff, 2'b10);
    wr(12'h0f0, 32'h1234_5678, 2'b10);
    // Direction toggle outside commissioning must not act.
    wr(`ENCPD_OFF_OUTW, 32'h1000_0000);
    wr(`ENCPD_OFF_OUTW, 32'h0);
    rd(`ENCPD_OFF_INW, 32'h0, 32'h1000_0000);
    done();
    // Preset on a rising command bit, acknowledged, then position equals the preset.
    pos(25'd1000);
    n0 = nvw;
    wr(`ENCPD_OFF_OUTW, 32'h8000_01f4);
    rd(`ENCPD_OFF_INW, 32'h8000_0000, 32'h8000_0000);
    wr(`ENCPD_OFF_OUTW, 32'h0);
    rd(`ENCPD_OFF_INW, 32'h0000_01f4, 32'h81ff_ffff);
    tests_run++;
    if (nvw <= n0) begin
      fails++;
      $display("MISMATCH nv_write pulses expected >%0d seen %0d", n0, nvw);
    end
    done();
    // Commissioning: mode bit clear, teach start shows raw position, stop shows steps.
    wr(`ENCPD_OFF_CFG, 32'h402);
    pos(25'd4000);
    rd(`ENCPD_OFF_INW, 32'h0, 32'h0400_0000);
    wr(`ENCPD_OFF_OUTW, 32'h4000_0000);
    rd(`ENCPD_OFF_INW, 32'h4000_0fa0, 32'h41ff_ffff);
    wr(`ENCPD_OFF_OUTW, 32'h2000_04d2);
    rd(`ENCPD_OFF_INW, 32'h6000_04d2, 32'h61ff_ffff);
    wr(`ENCPD_OFF_OUTW, 32'h0);
    rd(`ENCPD_OFF_INW, 32'h0, 32'h6000_0000);
    done();
    // Direction handshake: acknowledge while held, flip and store on the fall.
    n0 = nvw;
    wr(`ENCPD_OFF_OUTW, 32'h1000_0000);
    rd(`ENCPD_OFF_INW, 32'h1200_0001, 32'h1200_0001);
    wr(`ENCPD_OFF_OUTW, 32'h0);
    rd(`ENCPD_OFF_INW, 32'h1000_0000, 32'h1000_0000);
    rd(`ENCPD_OFF_NVDIR, 32'h1, 32'h1);
    tests_run++;
    if (nvw <= n0) begin
      fails++;
      $display("MISMATCH nv_write pulses expected >%0d seen %0d", n0, nvw);
    end
    // Normal mode follows the configured direction, commissioning the stored one.
    wr(`ENCPD_OFF_CFG, 32'h2);
    rd(`ENCPD_OFF_INW, 32'h0400_0000, 32'h1400_0000);
    wr(`ENCPD_OFF_CFG, 32'h402);
    rd(`ENCPD_OFF_INW, 32'h1000_0000, 32'h1400_0000);
    done();
    repeat (10) @(posedge clk);
    close_out();
  end
endmodule
`default_nettype wire
